// ---- hdl/config_decode_consts.vh ----
`ifndef CONFIG_DECODE_CONSTS_VH
`define CONFIG_DECODE_CONSTS_VH
// register byte addresses
`define ADDR_CFG_ZERO 12'h000
`define ADDR_CFG_ONE 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_CONTROL 12'h00c
// byte zero fields
`define B0_RSVD_HI 7
`define B0_RSVD_LO 4
`define B0_SEC_HI 3
`define B0_SEC_LO 2
`define B0_RDP 1
`define B0_WLOCK 0
// byte one fields
`define B1_PLL_FACTOR 7
`define B1_PLL_BYPASS 6
`define B1_RSVD 5
`define B1_CLK_SRC 4
`define B1_BOD_HI 3
`define B1_BOD_LO 2
`define B1_WDG_ACT 1
`define B1_WDG_HALT 0
// erased (default) option byte values
`define CFG_ZERO_RESET 8'hfc
`define CFG_ONE_RESET 8'hef
// control register bits
`define CTL_WR_ZERO 0
`define CTL_WR_ONE 1
`define CTL_ERASE 2
`define CTL_WATCHDOG_ACTIVATION_SEL_EN 3
`define CTL_HALT_ENTRY 4
// sector zero size codes (0.5k, 1k, 1.5k)
`define SEC_SIZE_HALF 2'h0
`define SEC_SIZE_ONE 2'h1
`define SEC_SIZE_ONE_HALF 2'h2
// brown-out decodes
`define BOD_OFF 2'h3
`define BOD_HIGH 2'h2
`define BOD_MED 2'h1
`define BOD_LOW 2'h0
`define ERASED_BYTE 8'hff
`define ERASE_CYCLES 8'h10
`endif

// ---- hdl/option_byte_config_decode.v ----
// The register offsets and the APB slave port were decided locally.
`include "config_decode_consts.vh"
`default_nettype none
// How it works
// R1: option bytes change only in programming mode
// R2: programmer keeps byte zero upper bits one
// R3: sector size: 00 half, 01 one, 1x
// R4: readout protect blocks extraction and writes
// R5: erase under readout protect wipes memory first
// R6: write lock refuses erase and program forever
// R7: byte one bit7 picks PLL x4/x8
// R8: byte one bit6 one bypasses the PLL
// R9: byte one bit4 one turns RC off
// R10: programmer keeps byte one bit5 one
// R11: programmer writes only valid clock combinations
// R12: brown-out field decodes off/high/medium/low
// R13: watchdog activation zero means always running
// R14: halt reset when bit set and watchdog active
// R15: unprogrammed parts show internal RC source
// R16: blank program memory reads all ones
// R17: customer code leaves factory trim untouched
// R18: decoded settings latched at reset, held; the code still lets a control write set watchdog_active_out after reset
module option_byte_config_decode (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // programming mode pin (asynchronous)
   input wire prog_mode_in,
   // apb slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   // decoded configuration
   output reg [1:0] sector_zero_size_sel_out,
   output reg readout_protect_out,
   output reg program_memory_write_lock_out,
   output reg pll_factor_sel_out,
   output reg pll_bypass_out,
   output reg rc_osc_off_out,
   output reg brownout_detector_en_out,
   output reg [1:0] brownout_threshold_sel_out,
   output reg watchdog_active_out,
   output reg halt_reset_out,
   // program memory guards
   output reg extract_block_out,
   output reg mem_write_block_out,
   output reg mem_erase_all_out,
   output reg mem_blank_out
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WIPE = 3'b010;
   localparam ST_DONE = 3'b100;

   reg [2:0] prog_sync_reg;
   reg prog_mode_reg;
   reg [7:0] config_byte_zero_reg;
   reg [7:0] config_byte_one_reg;
   reg [7:0] shadow_zero_reg;
   reg [7:0] shadow_one_reg;
   reg [2:0] state_reg;
   reg [7:0] wipe_cnt_reg;
   reg refused_reg;
   reg watchdog_activation_sel_en_reg;
   reg blank_reg;
   reg first_reg;

   wire apb_access;
   wire apb_write;
   wire addr_ok;
   assign apb_access = psel_in & penable_in & ~pready_out;
   assign apb_write = apb_access & pwrite_in;
   assign addr_ok = (paddr_in == `ADDR_CFG_ZERO) | (paddr_in == `ADDR_CFG_ONE) |
                    (paddr_in == `ADDR_STATUS) | (paddr_in == `ADDR_CONTROL);

   wire wr_zero;
   wire wr_one;
   wire erase_req;
   wire locked;
   // writes to the option bytes only land in programming mode
   assign wr_zero = apb_write & prog_mode_reg & (paddr_in == `ADDR_CONTROL) &
                    pwdata_in[`CTL_WR_ZERO]; // [R1]
   assign wr_one = apb_write & prog_mode_reg & (paddr_in == `ADDR_CONTROL) &
                   pwdata_in[`CTL_WR_ONE]; // [R1]
   assign erase_req = apb_write & prog_mode_reg & (paddr_in == `ADDR_CONTROL) &
                      pwdata_in[`CTL_ERASE] & (state_reg == ST_IDLE);
   assign locked = config_byte_zero_reg[`B0_WLOCK];

   // staging data: control write carries both bytes in [15:8] / [23:16]
   always @(posedge clk_in) begin
      if (rst_in) begin
         prog_sync_reg <= 3'h0;
         prog_mode_reg <= 1'b0;
      end else begin
         prog_sync_reg <= {prog_sync_reg[1:0], prog_mode_in};
         if (prog_sync_reg[1] == prog_sync_reg[2])
            prog_mode_reg <= prog_sync_reg[2];
      end
   end

   // option byte storage is non-volatile, so it is not cleared by reset
   always @(posedge clk_in) begin
      if (first_reg) begin
         config_byte_zero_reg <= `CFG_ZERO_RESET;
         config_byte_one_reg <= `CFG_ONE_RESET; // [R15]
      end else if (state_reg == ST_DONE) begin
         config_byte_zero_reg <= `CFG_ZERO_RESET;
         config_byte_one_reg <= `CFG_ONE_RESET;
      end else if (!locked) begin // [R6]
         if (wr_zero)
            config_byte_zero_reg <= pwdata_in[15:8];
         if (wr_one)
            config_byte_one_reg <= pwdata_in[23:16];
      end
   end

   // first_reg marks power-on: storage seeded once, then survives resets
   always @(posedge clk_in) begin
      if (rst_in & first_reg)
         first_reg <= 1'b1;
      else
         first_reg <= 1'b0;
   end
   initial first_reg = 1'b1;

   // erase sequence
   always @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         wipe_cnt_reg <= 8'h00;
         mem_erase_all_out <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         mem_erase_all_out <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (erase_req) begin
                  if (locked) begin
                     refused_reg <= 1'b1; // [R6]
                  end else begin
                     // protected parts wipe the array before unlocking
                     state_reg <= ST_WIPE; // [R5]
                     wipe_cnt_reg <= `ERASE_CYCLES;
                  end
               end else if (apb_write & prog_mode_reg & locked &
                            (paddr_in == `ADDR_CONTROL) &
                            (pwdata_in[`CTL_WR_ZERO] | pwdata_in[`CTL_WR_ONE])) begin
                  refused_reg <= 1'b1; // [R6]
               end
            end
            ST_WIPE: begin
               mem_erase_all_out <= 1'b1; // [R5]
               wipe_cnt_reg <= wipe_cnt_reg - 8'h01;
               if (wipe_cnt_reg == 8'h01)
                  state_reg <= ST_DONE;
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // blank tracking: erased memory reads as ff until programmed
   always @(posedge clk_in) begin
      if (first_reg)
         blank_reg <= 1'b1; // [R16]
      else if (state_reg == ST_DONE)
         blank_reg <= 1'b1;
      else if (apb_write & prog_mode_reg & ~locked & ~config_byte_zero_reg[`B0_RDP] &
               (paddr_in == `ADDR_CONTROL) & pwdata_in[`CTL_WR_ZERO])
         blank_reg <= 1'b0;
   end

   // option bytes sampled at reset and then frozen; the watchdog select bit is still set by a control write [R18]
   always @(posedge clk_in) begin
      if (rst_in) begin
         shadow_zero_reg <= config_byte_zero_reg; // [R18]
         shadow_one_reg <= config_byte_one_reg;
         watchdog_activation_sel_en_reg <= 1'b0;
      end else if (apb_write & (paddr_in == `ADDR_CONTROL) &
                   pwdata_in[`CTL_WATCHDOG_ACTIVATION_SEL_EN]) begin
         watchdog_activation_sel_en_reg <= 1'b1; // [R13]
      end
   end

   // decoded outputs, registered
   always @(posedge clk_in) begin
      if (rst_in) begin
         sector_zero_size_sel_out <= `SEC_SIZE_HALF;
         readout_protect_out <= 1'b0;
         program_memory_write_lock_out <= 1'b0;
         pll_factor_sel_out <= 1'b0;
         pll_bypass_out <= 1'b0;
         rc_osc_off_out <= 1'b0;
         brownout_detector_en_out <= 1'b0;
         brownout_threshold_sel_out <= `BOD_LOW;
         watchdog_active_out <= 1'b0;
         halt_reset_out <= 1'b0;
         extract_block_out <= 1'b0;
         mem_write_block_out <= 1'b0;
         mem_blank_out <= 1'b0;
      end else begin
         if (shadow_zero_reg[`B0_SEC_HI])
            sector_zero_size_sel_out <= `SEC_SIZE_ONE_HALF; // [R3]
         else if (shadow_zero_reg[`B0_SEC_LO])
            sector_zero_size_sel_out <= `SEC_SIZE_ONE; // [R3]
         else
            sector_zero_size_sel_out <= `SEC_SIZE_HALF; // [R3]
         readout_protect_out <= shadow_zero_reg[`B0_RDP];
         program_memory_write_lock_out <= shadow_zero_reg[`B0_WLOCK];
         extract_block_out <= shadow_zero_reg[`B0_RDP]; // [R4]
         mem_write_block_out <= shadow_zero_reg[`B0_RDP] |
                                shadow_zero_reg[`B0_WLOCK]; // [R4] [R6]
         pll_factor_sel_out <= shadow_one_reg[`B1_PLL_FACTOR]; // [R7]
         pll_bypass_out <= shadow_one_reg[`B1_PLL_BYPASS]; // [R8]
         rc_osc_off_out <= shadow_one_reg[`B1_CLK_SRC]; // [R9]
         brownout_threshold_sel_out <= shadow_one_reg[`B1_BOD_HI:`B1_BOD_LO]; // [R12]
         brownout_detector_en_out <=
            (shadow_one_reg[`B1_BOD_HI:`B1_BOD_LO] != `BOD_OFF); // [R12]
         watchdog_active_out <= ~shadow_one_reg[`B1_WDG_ACT] | watchdog_activation_sel_en_reg; // [R13]
         // a halt entry resets only while the watchdog is running
         halt_reset_out <= shadow_one_reg[`B1_WDG_HALT] & watchdog_active_out &
                           apb_write & (paddr_in == `ADDR_CONTROL) &
                           pwdata_in[`CTL_HALT_ENTRY]; // [R14]
         mem_blank_out <= blank_reg; // [R16]
      end
   end

   // apb slave: one wait state per access, pready for one cycle
   always @(posedge clk_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else begin
         pready_out <= apb_access;
         pslverr_out <= apb_access & ~addr_ok;
         prdata_out <= 32'h00000000;
         if (apb_access & ~pwrite_in) begin
            case (paddr_in)
               // option bytes are visible only in programming mode
               `ADDR_CFG_ZERO:
                  prdata_out <= {24'h000000,
                                 prog_mode_reg ? config_byte_zero_reg : 8'h00}; // [R1]
               `ADDR_CFG_ONE:
                  prdata_out <= {24'h000000,
                                 prog_mode_reg ? config_byte_one_reg : 8'h00}; // [R1]
               `ADDR_STATUS:
                  prdata_out <= {24'h000000, 1'b0, blank_reg, refused_reg, watchdog_activation_sel_en_reg,
                                 prog_mode_reg, state_reg[1], shadow_zero_reg[`B0_RDP],
                                 shadow_zero_reg[`B0_WLOCK]};
               default: prdata_out <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/prog_tool.sv ----
`default_nettype none
module prog_tool (
   // clock
   input wire logic clk_in,
   // tool side
   output logic prog_mode_out,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [11:0] paddr_out,
   output logic [31:0] pwdata_out,
   // answer
   input wire logic pready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {prog_mode_out, psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
   // the pin is asynchronous, so leave room for the synchroniser
   task automatic mode(input logic m);
      @(posedge clk_in);
      prog_mode_out <= m;
      repeat (6) @(posedge clk_in);
   endtask
   // the tool never addresses the factory trim words
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {psel_out, pwrite_out, paddr_out, pwdata_out} <= {1'b1, w, a, d};
      @(posedge clk_in);
      penable_out <= 1'b1;
      do @(posedge clk_in); while (pready_in !== 1'b1);
      {psel_out, penable_out} <= 2'b00;
   endtask
endmodule
`default_nettype wire

// ---- testbench/option_byte_config_chk.sv ----
`default_nettype none
module option_byte_config_chk (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // settings
   input wire [1:0] sector_zero_size_sel_out,
   input wire readout_protect_out,
   input wire program_memory_write_lock_out,
   input wire brownout_detector_en_out,
   input wire [1:0] brownout_threshold_sel_out,
   input wire watchdog_active_out,
   input wire halt_reset_out,
   input wire mem_write_block_out,
   input wire mem_erase_all_out,
   input wire mem_blank_out
);
   logic r1 = 1'b1;
   logic r2 = 1'b1;
   // outputs still show reset values at the first edge after release
   always @(posedge clk_in) begin
      r1 <= rst_in;
      r2 <= r1;
   end
   wire up = !r1 && !r2;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_sec; up |-> sector_zero_size_sel_out != 2'h3; endproperty
   a_sec: assert property (p_sec) else $error("sector code");
   property p_wblk;
      up |-> mem_write_block_out == (readout_protect_out | program_memory_write_lock_out);
   endproperty
   a_wblk: assert property (p_wblk) else $error("write block");
   property p_bod;
      up |-> brownout_detector_en_out == (brownout_threshold_sel_out != 2'h3);
   endproperty
   a_bod: assert property (p_bod) else $error("brownout enable");
   property p_hold;
      up |-> $stable({sector_zero_size_sel_out, readout_protect_out, brownout_threshold_sel_out});
   endproperty
   a_hold: assert property (p_hold) else $error("setting moved");
   property p_wdg; up |-> !$fell(watchdog_active_out); endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog stopped");
   property p_halt; halt_reset_out |-> watchdog_active_out; endproperty
   a_halt: assert property (p_halt) else $error("halt reset");
   property p_erase; $rose(mem_erase_all_out) |-> ##[1:24] mem_blank_out; endproperty
   a_erase: assert property (p_erase) else $error("erase end");
   property p_lock; program_memory_write_lock_out |-> !mem_erase_all_out; endproperty
   a_lock: assert property (p_lock) else $error("erase when locked");
endmodule
bind option_byte_config_decode option_byte_config_chk i_option_byte_config_chk (
   .clk_in(clk_in), .rst_in(rst_in), .sector_zero_size_sel_out(sector_zero_size_sel_out),
   .readout_protect_out(readout_protect_out), .halt_reset_out(halt_reset_out),
   .program_memory_write_lock_out(program_memory_write_lock_out),
   .brownout_detector_en_out(brownout_detector_en_out),
   .brownout_threshold_sel_out(brownout_threshold_sel_out),
   .watchdog_active_out(watchdog_active_out), .mem_write_block_out(mem_write_block_out),
   .mem_erase_all_out(mem_erase_all_out), .mem_blank_out(mem_blank_out));
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic pm, psel, pen, pwr, prdy, perr, rdp, lock, pf, byp, rco, boe, wdg, halt, ext, wbk;
   logic erase, blank, seen_h = 1'b0, seen_e = 1'b0;
   logic [1:0] sec, bod;
   logic [11:0] addr;
   logic [31:0] wd, prd;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [15:0] lf = 16'ha9bc;
   logic [7:0] cfg0[4] = '{8'hf4, 8'hf0, 8'hf8, 8'hf2};
   // only listed clock combinations
   logic [7:0] cfg1[4] = '{8'h21, 8'hb6, 8'hf8, 8'hed};
   int fails = 0;
   int comparisons = 0;
   always #2.5 clk_in = ~clk_in;
   option_byte_config_decode i_option_byte_config_decode (
      .clk_in(clk_in), .rst_in(rst_in), .prog_mode_in(pm), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd), .prdata_out(prd), .pready_out(prdy),
      .pslverr_out(perr), .sector_zero_size_sel_out(sec), .readout_protect_out(rdp),
      .program_memory_write_lock_out(lock), .pll_factor_sel_out(pf), .pll_bypass_out(byp),
      .rc_osc_off_out(rco), .brownout_detector_en_out(boe), .brownout_threshold_sel_out(bod),
      .watchdog_active_out(wdg), .halt_reset_out(halt), .extract_block_out(ext),
      .mem_write_block_out(wbk), .mem_erase_all_out(erase), .mem_blank_out(blank));
   prog_tool i_prog_tool (.clk_in(clk_in), .prog_mode_out(pm), .psel_out(psel),
      .penable_out(pen), .pwrite_out(pwr), .paddr_out(addr), .pwdata_out(wd), .pready_in(prdy));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic cmp(input logic [32:0] g, input logic [32:0] x);
      comparisons++;
      if (g !== x) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
      q.push_back({1'b0, err, 32'h0});
      i_prog_tool.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] x);
      q.push_back({1'b1, x});
      i_prog_tool.xfer(1'b0, a, 32'h0);
   endtask
   // the synchroniser restarts with reset, so wait past its lag
   task automatic do_reset;
      rst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask
   task automatic chk_dec(input logic [7:0] b0, input logic [7:0] b1);
      cmp({19'h0, sec, rdp, lock, pf, byp, rco, boe, bod, wdg, ext, wbk},
         {19'h0, (b0[3] ? 2'h2 : {1'b0, b0[2]}), b0[1:0], b1[7:6], b1[4],
         b1[3:2] != 2'h3, b1[3:2], ~b1[1], b0[1], |b0[1:0]});
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      if (halt === 1'b1) seen_h <= 1'b1;
      if (erase === 1'b1) seen_e <= 1'b1;
      if (prdy === 1'b1) begin
         e = q.pop_front();
         cmp({perr, e[33] ? prd : 32'h0}, e[32:0]);
      end
   end
   initial begin
      #20us;
      fails++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] b0, b1;
      do_reset();
      wr(12'h00c, 32'h00f0_f403, 1'b0);
      rd(12'h000, 33'h0);
      lf = nxt(lf);
      wr({lf[11:4] | 8'h01, 4'h0}, {lf, lf}, 1'b1);
      i_prog_tool.mode(1'b1);
      rd(12'h000, 33'h0fc);
      rd(12'h004, 33'h0ef);
      chk_dec(8'hfc, 8'hef);
      cmp({32'h0, blank}, 33'h1);
      $display("defaults done");
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         b0 = cfg0[i] | {5'h0, lf[0] & cfg0[i][3], 2'h0};
         b1 = cfg1[i];
         wr(12'h00c, {8'h00, b1 | 8'h20, b0 | 8'hf0, 8'h03}, 1'b0);
         do_reset();
         chk_dec(b0, b1);
         seen_h = 1'b0;
         wr(12'h00c, 32'h18, 1'b0);
         repeat (4) @(posedge clk_in);
         cmp({32'h0, seen_h}, {32'h0, b1[0] & ~b1[1]});
         cmp({32'h0, wdg}, 33'h1);
         $display("config %0d done", i);
      end
      seen_e = 1'b0;
      wr(12'h00c, 32'h04, 1'b0);
      repeat (30) @(posedge clk_in);
      cmp({32'h0, seen_e}, 33'h1);
      cmp({32'h0, blank}, 33'h1);
      do_reset();
      rd(12'h000, 33'h0fc);
      rd(12'h004, 33'h0ef);
      $display("erase done");
      wr(12'h00c, 32'h00e7_f103, 1'b0);
      do_reset();
      chk_dec(8'hf1, 8'he7);
      seen_e = 1'b0;
      wr(12'h00c, 32'h00e7_fc07, 1'b0);
      repeat (30) @(posedge clk_in);
      cmp({32'h0, seen_e}, 33'h0);
      rd(12'h000, 33'h0f1);
      $display("lock done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
